// ---- verilog/vdsc_map.vh ----
// Register map constants of the video DAC system control block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef VDSC_MAP_VH
`define VDSC_MAP_VH

// Sub-addresses seen over the serial control bus.
`define VDSC_SUB_VERSION   8'h02
`define VDSC_SUB_SYSCTL    8'h03

// Field positions inside the system control register.
`define VDSC_BIT_DIRECT    7
`define VDSC_BIT_DLLBYP    6
`define VDSC_BIT_CBAR      5
`define VDSC_BIT_DLLLOW    4
`define VDSC_BIT_DACPD     3
`define VDSC_BIT_CHIPPD    2
`define VDSC_BIT_ROLE      1
`define VDSC_BIT_SRSTN     0

// Reset value: only the active-low software reset bit is set.
`define VDSC_SYSCTL_RST    8'h01

// Silicon version word; the value is arbitrary.
`define VDSC_VERSION_VAL   8'h5A

// Seven-bit serial bus slave address; the value is arbitrary.
`define VDSC_BUS_ADDR      7'h20

// Half-rate clock enable divides the system clock by this count.
`define VDSC_HALF_DIV      2'h2

`endif

// ---- verilog/vdsc_rate_div.v ----
// Enable divider: one-cycle pulse every VDSC_HALF_DIV system clocks.
// Assumes a single clock; run low holds the counter at zero.
`timescale 1ns/1ps
`include "vdsc_map.vh"

module vdsc_rate_div (
  sys_clk,
  rstn,
  run,
  en_o
);
  input  wire       sys_clk;
  input  wire       rstn;
  input  wire       run;
  output reg        en_o;

  reg  [1:0] cnt_r;
  wire [1:0] cnt_nxt;

  assign cnt_nxt = (cnt_r == (`VDSC_HALF_DIV - 2'h1)) ? 2'h0 : cnt_r + 2'h1;

  always @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_r <= 2'h0;
      en_o  <= 1'b0;
    end else if (!run) begin
      cnt_r <= 2'h0;
      en_o  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      en_o  <= (cnt_r == (`VDSC_HALF_DIV - 2'h1));
    end
  end

endmodule // vdsc_rate_div

// ---- verilog/vdsc_sys_ctl.v ----
// System control of a video D/A back end: serial control bus slave,
// version and system control registers, clock mode and power controls.
// Assumes bus pins and format inputs are synchronous to sys_clk, and an
// external pull-up resolves the open-drain data line.
`timescale 1ns/1ps
`include "vdsc_map.vh"

module vdsc_sys_ctl (
  sys_clk,
  rstn,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  fmt_half_rate_need,
  dtg_pc_mode,
  clk_direct_o,
  interp_2x_ok_o,
  dll_active_o,
  clk2x_from_pin_o,
  dll_low_range_o,
  half_rate_en_o,
  colorbar_on_o,
  video_in_ignore_o,
  dac_pwdn_o,
  logic_pwdn_o,
  sync_slave_o,
  timing_master_o,
  video_request_o,
  func_rst_n_o
);
  input  wire       sys_clk;
  input  wire       rstn;
  input  wire       scl_in;
  input  wire       sda_in;
  output reg        sda_out;
  output reg        sda_oe;
  input  wire       fmt_half_rate_need;
  input  wire       dtg_pc_mode;
  output reg        clk_direct_o;
  output reg        interp_2x_ok_o;
  output reg        dll_active_o;
  output reg        clk2x_from_pin_o;
  output reg        dll_low_range_o;
  output wire       half_rate_en_o;
  output reg        colorbar_on_o;
  output reg        video_in_ignore_o;
  output reg        dac_pwdn_o;
  output reg        logic_pwdn_o;
  output reg        sync_slave_o;
  output reg        timing_master_o;
  output reg        video_request_o;
  output reg        func_rst_n_o;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX   = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_TX   = 3'h3;
  localparam [2:0] ST_MACK = 3'h4;

  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_SUB  = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  reg  [2:0] state_r;
  reg  [1:0] phase_r;
  reg  [7:0] shift_r;
  reg  [2:0] bit_cnt_r;
  reg        byte_done_r;
  reg        rd_mode_r;
  reg        mack_ok_r;
  reg  [7:0] sub_r;
  reg  [7:0] sysctl_r;
  reg        scl_q;
  reg        sda_q;
  reg  [7:0] rd_data;

  wire       scl_rise;
  wire       scl_fall;
  wire       bus_start;
  wire       bus_stop;
  wire       half_run;

  ////////////////////////////////////////////////////////////////////////////
  // Bus line edge and condition detection.

  assign scl_rise  = scl_in & ~scl_q;
  assign scl_fall  = ~scl_in & scl_q;
  assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
  assign bus_stop  = scl_in & scl_q & ~sda_q & sda_in;

  always @(posedge sys_clk) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer. Unmapped sub-addresses read as zero.

  always @* begin
    case (sub_r)
      `VDSC_SUB_VERSION: rd_data = `VDSC_VERSION_VAL;
      `VDSC_SUB_SYSCTL:  rd_data = sysctl_r;
      default:           rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial control slave. It keeps running during chip power-down and
  // software reset, since software must be able to undo both.

  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_r     <= ST_IDLE;
      phase_r     <= PH_ADDR;
      shift_r     <= 8'h00;
      bit_cnt_r   <= 3'h0;
      byte_done_r <= 1'b0;
      rd_mode_r   <= 1'b0;
      mack_ok_r   <= 1'b0;
      sub_r       <= 8'h00;
      sysctl_r    <= `VDSC_SYSCTL_RST;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
    end else if (bus_start) begin
      state_r     <= ST_RX;
      phase_r     <= PH_ADDR;
      bit_cnt_r   <= 3'h0;
      byte_done_r <= 1'b0;
      sda_oe      <= 1'b0;
    end else if (bus_stop) begin
      state_r     <= ST_IDLE;
      sda_oe      <= 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_in};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              byte_done_r <= 1'b1;
            end
          end else if (scl_fall && byte_done_r) begin
            byte_done_r <= 1'b0;
            case (phase_r)
              PH_ADDR: begin
                if (shift_r[7:1] == `VDSC_BUS_ADDR) begin
                  rd_mode_r <= shift_r[0];
                  sda_oe    <= 1'b1;
                  state_r   <= ST_ACK;
                end else begin
                  state_r   <= ST_IDLE;
                end
              end
              PH_SUB: begin
                sub_r   <= shift_r;
                sda_oe  <= 1'b1;
                state_r <= ST_ACK;
              end
              default: begin
                // The version word ignores writes; register contents
                // survive software reset because nothing here looks at it.
                if (sub_r == `VDSC_SUB_SYSCTL) begin
                  sysctl_r <= shift_r;
                end
                sda_oe  <= 1'b1;
                state_r <= ST_ACK;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 3'h0;
            if (phase_r == PH_ADDR && rd_mode_r) begin
              shift_r <= rd_data;
              sda_oe  <= ~rd_data[7];
              state_r <= ST_TX;
            end else begin
              sda_oe  <= 1'b0;
              state_r <= ST_RX;
              if (phase_r == PH_DATA) begin
                sub_r <= sub_r + 8'h01;
              end
              phase_r <= (phase_r == PH_ADDR) ? PH_SUB : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 3'h7) begin
              sda_oe  <= 1'b0;
              sub_r   <= sub_r + 8'h01;
              state_r <= ST_MACK;
            end else begin
              shift_r   <= {shift_r[6:0], 1'b0};
              sda_oe    <= ~shift_r[6];
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_ok_r <= ~sda_in;
          end else if (scl_fall) begin
            if (mack_ok_r) begin
              shift_r   <= rd_data;
              sda_oe    <= ~rd_data[7];
              bit_cnt_r <= 3'h0;
              state_r   <= ST_TX;
            end else begin
              state_r   <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock mode and power controls, registered so every output is a flop.
  // Master timing is only meaningful in PC-graphics mode; outside it the
  // role bit still takes effect, as software is trusted to keep to that.

  always @(posedge sys_clk) begin
    if (!rstn) begin
      clk_direct_o      <= 1'b0;
      interp_2x_ok_o    <= 1'b1;
      dll_active_o      <= 1'b1;
      clk2x_from_pin_o  <= 1'b0;
      dll_low_range_o   <= 1'b0;
      colorbar_on_o     <= 1'b0;
      video_in_ignore_o <= 1'b0;
      dac_pwdn_o        <= 1'b0;
      logic_pwdn_o      <= 1'b0;
      sync_slave_o      <= 1'b1;
      timing_master_o   <= 1'b0;
      video_request_o   <= 1'b0;
      func_rst_n_o      <= 1'b1;
    end else begin
      clk_direct_o      <= sysctl_r[`VDSC_BIT_DIRECT];
      interp_2x_ok_o    <= ~sysctl_r[`VDSC_BIT_DIRECT];
      dll_active_o      <= ~sysctl_r[`VDSC_BIT_DIRECT] & ~sysctl_r[`VDSC_BIT_DLLBYP]
                           & ~sysctl_r[`VDSC_BIT_CHIPPD];
      clk2x_from_pin_o  <= sysctl_r[`VDSC_BIT_DIRECT] | sysctl_r[`VDSC_BIT_DLLBYP];
      dll_low_range_o   <= sysctl_r[`VDSC_BIT_DLLLOW];
      colorbar_on_o     <= sysctl_r[`VDSC_BIT_CBAR] & sysctl_r[`VDSC_BIT_ROLE]
                           & dtg_pc_mode;
      video_in_ignore_o <= sysctl_r[`VDSC_BIT_CBAR] & sysctl_r[`VDSC_BIT_ROLE]
                           & dtg_pc_mode;
      dac_pwdn_o        <= sysctl_r[`VDSC_BIT_DACPD];
      logic_pwdn_o      <= sysctl_r[`VDSC_BIT_CHIPPD];
      sync_slave_o      <= ~sysctl_r[`VDSC_BIT_ROLE];
      timing_master_o   <= sysctl_r[`VDSC_BIT_ROLE];
      video_request_o   <= sysctl_r[`VDSC_BIT_ROLE] & sysctl_r[`VDSC_BIT_SRSTN]
                           & ~sysctl_r[`VDSC_BIT_CHIPPD];
      func_rst_n_o      <= sysctl_r[`VDSC_BIT_SRSTN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-rate enable. It runs in direct-clock mode too, but stops while the
  // logic is powered down or held in software reset.

  assign half_run = fmt_half_rate_need & sysctl_r[`VDSC_BIT_SRSTN]
                    & ~sysctl_r[`VDSC_BIT_CHIPPD];

  vdsc_rate_div u_half_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (half_run),
    .en_o    (half_rate_en_o)
  );

endmodule // vdsc_sys_ctl

// ---- tb/vdsc_sys_ctl_sva.sv ----
// Checker for the video DAC system control outputs.
// Assumes it sees only the top-level ports of vdsc_sys_ctl.
`timescale 1ns/1ps
module vdsc_sys_ctl_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic dtg_pc_mode,
  input wire logic fmt_half_rate_need,
  input wire logic clk_direct_o,
  input wire logic interp_2x_ok_o,
  input wire logic dll_active_o,
  input wire logic clk2x_from_pin_o,
  input wire logic dll_low_range_o,
  input wire logic half_rate_en_o,
  input wire logic colorbar_on_o,
  input wire logic video_in_ignore_o,
  input wire logic logic_pwdn_o,
  input wire logic sync_slave_o,
  input wire logic timing_master_o,
  input wire logic video_request_o,
  input wire logic func_rst_n_o
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  sequence s_need;
    (fmt_half_rate_need && func_rst_n_o && !logic_pwdn_o) [*4];
  endsequence
  sequence s_pd;
    logic_pwdn_o [*3];
  endsequence
  property p_odrain;
    sda_oe |-> !sda_out;
  endproperty
  a_odrain: assert property (p_odrain) else $error("data line driven high");
  property p_direct;
    clk_direct_o |-> !interp_2x_ok_o && !dll_active_o && clk2x_from_pin_o;
  endproperty
  a_direct: assert property (p_direct) else $error("direct clock outputs wrong");
  property p_bypass;
    !clk_direct_o && !logic_pwdn_o |-> dll_active_o == !clk2x_from_pin_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("clock source wrong");
  property p_cbar;
    colorbar_on_o |-> timing_master_o && $past(dtg_pc_mode) && video_in_ignore_o;
  endproperty
  a_cbar: assert property (p_cbar) else $error("color bar gating wrong");
  property p_role;
    sync_slave_o == !timing_master_o;
  endproperty
  a_role: assert property (p_role) else $error("timing role outputs clash");
  property p_pwdn;
    logic_pwdn_o |-> !dll_active_o && !video_request_o;
  endproperty
  a_pwdn: assert property (p_pwdn) else $error("power-down leaves logic on");
  property p_srst;
    video_request_o |-> func_rst_n_o && timing_master_o;
  endproperty
  a_srst: assert property (p_srst) else $error("request outside master run");
  // The divider pulses only on every second system clock while it runs,
  // so the last pulse of a window may sit in the cycle before it ends.
  property p_half;
    s_need |-> half_rate_en_o || $past(half_rate_en_o);
  endproperty
  a_half: assert property (p_half) else $error("half-rate enable missing");
  property p_pulse;
    half_rate_en_o |=> !half_rate_en_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("half-rate enable too long");
  property p_hpd;
    s_pd |-> !half_rate_en_o;
  endproperty
  a_hpd: assert property (p_hpd) else $error("half-rate runs in power-down");
  property p_rst;
    !$past(rstn) |-> !clk_direct_o && dll_active_o && !dll_low_range_o && func_rst_n_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule // vdsc_sys_ctl_chk

bind vdsc_sys_ctl vdsc_sys_ctl_chk u_chk (.*);

// ---- tb/vdsc_vid_src.sv ----
// Behavioural video source facing the block's format and request pins.
// Assumes the bench sets the format choices; it counts request cycles.
`timescale 1ns/1ps
module vdsc_vid_src (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       pc_cfg,
  input  wire logic       hr_cfg,
  input  wire logic       video_request,
  output reg              fmt_half_rate_need,
  output reg              dtg_pc_mode,
  output reg        [7:0] req_cnt
);
  // Format flags come from registered logic, as a real source would give.
  // Only the request counter is reset; a source keeps its format anyway.
  always @(posedge sys_clk) begin
    dtg_pc_mode <= pc_cfg;
    fmt_half_rate_need <= hr_cfg;
    if (!rstn) begin
      req_cnt <= 8'h00;
    end else if (video_request) begin
      req_cnt <= req_cnt + 8'h01;
    end
  end
endmodule // vdsc_vid_src

// ---- tb/video_dac_system_control_bench.sv ----
// Testbench for the video DAC system control block.
// Assumes a 100 MHz sys_clk and a pull-up on the serial data line.
`timescale 1ns/1ps
`include "vdsc_map.vh"
module video_dac_system_control_bench;
  // Each row holds the PC-mode flag above the value written to system control.
  // Master timing is only ever set while PC mode is on, as software must.
  localparam [89:0] ROWS = {9'h080, 9'h041, 9'h011, 9'h009, 9'h105,
                            9'h123, 9'h0E1, 9'h121, 9'h103, 9'h000};
  reg         sys_clk, rstn, scl, m_sda, pc, hr, a;
  reg  [7:0]  d, v;
  wire        sda_out, sda_oe, fmt, dpc, hre, vreq;
  wire [12:0] st;
  wire [7:0]  cnt;
  integer     failures, n_compared, i;
  // The data line is open drain: the pull-up wins unless someone pulls low.
  wire        sda_w = m_sda & ~(sda_oe & ~sda_out);
  assign st[1] = vreq;
  vdsc_vid_src i_src (.sys_clk(sys_clk), .rstn(rstn), .pc_cfg(pc), .hr_cfg(hr),
    .video_request(vreq), .fmt_half_rate_need(fmt), .dtg_pc_mode(dpc), .req_cnt(cnt));
  vdsc_sys_ctl i_dut (.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .fmt_half_rate_need(fmt), .dtg_pc_mode(dpc),
    .clk_direct_o(st[12]), .interp_2x_ok_o(st[11]), .dll_active_o(st[10]),
    .clk2x_from_pin_o(st[9]), .dll_low_range_o(st[8]), .half_rate_en_o(hre),
    .colorbar_on_o(st[7]), .video_in_ignore_o(st[6]), .dac_pwdn_o(st[5]),
    .logic_pwdn_o(st[4]), .sync_slave_o(st[3]), .timing_master_o(st[2]),
    .video_request_o(vreq), .func_rst_n_o(st[0]));
  ////////////////////////////////////////
  function [12:0] ex(input [7:0] c, input p);
    ex = {c[7], ~c[7], ~c[7] & ~c[6] & ~c[2], c[7] | c[6], c[4], {2{c[5] & c[1] & p}},
          c[3], c[2], ~c[1], c[1], c[1] & c[0] & ~c[2], c[0]};
  endfunction
  task w(input integer n);
    begin
      repeat (n) @(negedge sys_clk);
    end
  endtask
  task miss(input [15:0] g, input [15:0] e);
    begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_st(input [12:0] g, input [12:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miss({3'h0, g}, {3'h0, e});
      end
    end
  endtask
  task chk_byte(input [7:0] g, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miss({8'h00, g}, {8'h00, e});
      end
    end
  endtask
  task chk_ack(input g, input e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miss({15'h0000, g}, {15'h0000, e});
      end
    end
  endtask
  task chk_cnt(input [7:0] g, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miss({8'h00, g}, {8'h00, e});
      end
    end
  endtask
  task bitx(input b, output r);
    begin
      m_sda = b;
      w(2);
      scl = 1'b1;
      w(2);
      r = sda_w;
      w(1);
      scl = 1'b0;
      w(2);
    end
  endtask
  task bytex(input [7:0] b, input ma, output [7:0] r, output ak);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        bitx(b[k], r[k]);
      end
      bitx(ma, ak);
      ak = ~ak;
    end
  endtask
  task go;
    begin
      m_sda = 1'b1;
      w(2);
      scl = 1'b1;
      w(2);
      m_sda = 1'b0;
      w(2);
      scl = 1'b0;
      w(2);
    end
  endtask
  task halt;
    begin
      m_sda = 1'b0;
      w(2);
      scl = 1'b1;
      w(2);
      m_sda = 1'b1;
      w(2);
    end
  endtask
  task wr(input [7:0] s, input [7:0] x);
    begin
      go;
      bytex({`VDSC_BUS_ADDR, 1'b0}, 1'b1, d, a);
      bytex(s, 1'b1, d, a);
      bytex(x, 1'b1, d, a);
      halt;
    end
  endtask
  task rd(input [7:0] s, output [7:0] r);
    begin
      go;
      bytex({`VDSC_BUS_ADDR, 1'b0}, 1'b1, d, a);
      bytex(s, 1'b1, d, a);
      go;
      bytex({`VDSC_BUS_ADDR, 1'b1}, 1'b1, d, a);
      bytex(8'hFF, 1'b1, r, a);
      halt;
    end
  endtask
  task cnt_hre(output [7:0] n);
    begin
      n = 8'h00;
      repeat (20) begin
        w(1);
        n = n + {7'h00, hre};
      end
    end
  endtask
  task cnt_req(output [7:0] n);
    begin
      n = cnt;
      w(20);
      n = cnt - n;
    end
  endtask
  task report_and_stop;
    begin
      $display("failures=%0d n_compared=%0d", failures, n_compared);
      if (failures == 0 && n_compared > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // The tests need about 8,000 cycles; the limit allows five times that.
  initial begin
    #400000;
    failures = failures + 1;
    report_and_stop;
  end
  initial begin
    failures = 0;
    n_compared = 0;
    rstn = 1'b0;
    scl = 1'b1;
    m_sda = 1'b1;
    pc = 1'b0;
    hr = 1'b0;
    w(8);
    rstn = 1'b1;
    w(2);
    for (i = 0; i < 10; i = i + 1) begin
      v = ROWS[i*9 +: 8];
      pc = ROWS[i*9+8];
      wr(`VDSC_SUB_SYSCTL, v);
      w(3);
      chk_st(st, ex(v, pc));
      rd(`VDSC_SUB_SYSCTL, d);
      chk_byte(d, v);
    end
    rd(`VDSC_SUB_VERSION, d);
    chk_byte(d, `VDSC_VERSION_VAL);
    wr(`VDSC_SUB_VERSION, 8'hA5);
    rd(`VDSC_SUB_VERSION, d);
    chk_byte(d, `VDSC_VERSION_VAL);
    rd(8'h44, d);
    chk_byte(d, 8'h00);
    go;
    bytex(8'h30, 1'b1, d, a);
    halt;
    chk_ack(a, 1'b0);
    go;
    bytex({`VDSC_BUS_ADDR, 1'b0}, 1'b1, d, a);
    halt;
    chk_ack(a, 1'b1);
    // Half-rate pulses must survive direct clocking but stop in power-down.
    hr = 1'b1;
    wr(`VDSC_SUB_SYSCTL, 8'h81);
    cnt_hre(v);
    chk_cnt(v, 8'h0A);
    wr(`VDSC_SUB_SYSCTL, 8'h85);
    cnt_hre(v);
    chk_cnt(v, 8'h00);
    pc = 1'b1;
    wr(`VDSC_SUB_SYSCTL, 8'h03);
    cnt_req(v);
    chk_cnt(v, 8'h14);
    wr(`VDSC_SUB_SYSCTL, 8'h02);
    cnt_req(v);
    chk_cnt(v, 8'h00);
    // Ending the soft reset pulse, as after a reconnect, brings requests back.
    wr(`VDSC_SUB_SYSCTL, 8'h03);
    cnt_req(v);
    chk_cnt(v, 8'h14);
    wr(`VDSC_SUB_SYSCTL, 8'hDE);
    rstn = 1'b0;
    w(8);
    rstn = 1'b1;
    w(2);
    chk_st(st, ex(8'h01, pc));
    rd(`VDSC_SUB_SYSCTL, d);
    chk_byte(d, 8'h01);
    report_and_stop;
  end
endmodule // video_dac_system_control_bench
